// ===== sim/rcf_top_bench.sv
// Register level bench of the reset cause block
`timescale 1ns/1ps
`include "rcf_defs.vh"

module rcf_top_bench;
   // Clock, reset and bus drive
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   // Reset events in flag order, and boot finished
   reg [5:0] ev = 6'h00;
   reg boot_done = 1'b0;
   // Outputs and last answer
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [5:0] reset_cause_q;
   wire boot_pending_q;
   wire irq_q;
   reg [31:0] rdat;
   reg rerr;
   // Counters
   integer fails = 0;
   integer cmp_count = 0;
   integer i;

   always #20 pclk = ~pclk;

   rcf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .por_evt(ev[0]), .bod_evt(ev[1]), .ext_evt(ev[2]), .wdt_evt(ev[3]),
      .sw_evt(ev[4]), .dbg_evt(ev[5]), .boot_done(boot_done),
      .reset_cause_q(reset_cause_q), .boot_pending_q(boot_pending_q),
      .irq_q(irq_q));

   // Compare and count
   task chk(input [31:0] got, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   end
   endtask

   // One APB transfer; answer taken at the edge that sees pready
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Wait for the answer; only the watchdog ends a hung wait
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   // Read and compare data and error flag
   task rd(input [11:0] a, input [31:0] exp, input eexp);
   begin
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
      chk(rerr, eexp);
   end
   endtask

   // One cycle event pulse, then time for the flags to settle
   task pulse(input [5:0] m);
   begin
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 6'h00;
      repeat (3) @(posedge pclk);
   end
   endtask

   // Verdict and end of run
   task give_verdict;
   begin
      if (fails == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   // Watchdog against a hung transfer
   initial
   begin
      #100000;
      fails = fails + 1;
      give_verdict;
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(`RCF_OFS_CAUSE, 32'h01, 1'b0);
      rd(`RCF_OFS_BOOT, 32'h01, 1'b0);
      pulse(6'h08);
      rd(`RCF_OFS_CAUSE, 32'h01, 1'b0);
      @(posedge pclk);
      boot_done <= 1'b1;
      @(posedge pclk);
      boot_done <= 1'b0;
      rd(`RCF_OFS_BOOT, 32'h00, 1'b0);
      // Sources one by one, flags accumulate
      for (i = 1; i < 6; i = i + 1)
      begin
         pulse(6'h01 << i);
         rd(`RCF_OFS_CAUSE, (32'h2 << i) - 1, 1'b0);
      end
      apb(1'b1, `RCF_OFS_CAUSE, 32'hffff_ffea);
      rd(`RCF_OFS_CAUSE, 32'h15, 1'b0);
      apb(1'b1, `RCF_OFS_CAUSE, 32'h01);
      rd(`RCF_OFS_CAUSE, 32'h14, 1'b0);
      // Interrupt raised, cleared by read, masked
      apb(1'b1, `RCF_OFS_IMASK, 32'h3f);
      repeat (3) @(posedge pclk);
      chk(irq_q, 1'b1);
      rd(`RCF_OFS_ISTAT, 32'h3f, 1'b0);
      repeat (3) @(posedge pclk);
      chk(irq_q, 1'b0);
      apb(1'b1, `RCF_OFS_IMASK, 32'h10);
      pulse(6'h04);
      chk(irq_q, 1'b0);
      pulse(6'h10);
      chk(irq_q, 1'b1);
      rd(`RCF_OFS_ISTAT, 32'h14, 1'b0);
      rd(`RCF_OFS_IMASK, 32'h10, 1'b0);
      rd(12'h010, 32'h0, 1'b1);
      apb(1'b1, 12'h010, 32'h3f);
      chk(rerr, 1'b1);
      // Power-on event after boot, then a blocked source
      pulse(6'h01);
      rd(`RCF_OFS_CAUSE, 32'h01, 1'b0);
      pulse(6'h20);
      rd(`RCF_OFS_CAUSE, 32'h01, 1'b0);
      apb(1'b1, `RCF_OFS_CAUSE, 32'h01);
      rd(`RCF_OFS_CAUSE, 32'h00, 1'b0);
      // Reset in mid-run restores the power-on flag
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`RCF_OFS_CAUSE, 32'h01, 1'b0);
      give_verdict;
   end
endmodule // rcf_top_bench

// ===== sim/rcf_top_sva.sv
// Port assertions of the reset cause block
`timescale 1ns/1ps

module rcf_chk
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB side
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Events and block state
   input wire por_evt,
   input wire bod_evt,
   input wire ext_evt,
   input wire wdt_evt,
   input wire sw_evt,
   input wire dbg_evt,
   input wire boot_done,
   input wire [5:0] reset_cause_q,
   input wire boot_pending_q,
   input wire irq_q
);
   // Raw events in flag order
   wire [5:0] ev = {dbg_evt, sw_evt, wdt_evt, ext_evt, bod_evt, por_evt};
   // Flag part of the write data
   wire [5:0] wmask = pwdata[5:0];
   // Completing write of the cause register
   wire wr_cause = psel & penable & pready & pwrite & (paddr == 12'h000);
   // One of the four decoded words
   wire mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'b00);
   genvar i;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Access phase still waiting, then a one cycle answer
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_answer; pready ##1 !pready; endsequence

   a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("answer not after one wait state");
   a_ready_pulse: assert property (s_wait |=> s_answer)
      else $error("answer not a single cycle");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("error flag wrong for address");
   a_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_top_zero: assert property (pready |-> prdata[31:6] == 26'h0)
      else $error("upper read bits not zero");
   a_por_force: assert property (por_evt |-> ##2 (reset_cause_q == 6'h01 && boot_pending_q))
      else $error("power-on did not leave only bit 0");
   a_boot_block: assert property (boot_pending_q |=> ((reset_cause_q & ~$past(reset_cause_q)) & 6'h3e) == 6'h00)
      else $error("flag set while boot pending");
   a_w1c_clear: assert property (wr_cause && ev == 6'h00 |-> ##2 reset_cause_q == ($past(reset_cause_q) & ~$past(wmask, 2)))
      else $error("write-one clear wrong");
   // Each non power-on source sets its own bit once boot is done
   for (i = 1; i < 6; i = i + 1)
   begin : g_evt
      a_evt_set: assert property (ev[i] && !por_evt && !boot_pending_q && !$past(por_evt) ##1 !por_evt |=> reset_cause_q[i])
         else $error("event flag not set");
   end
endmodule // rcf_chk

bind rcf_top rcf_chk chk (.*);

// ===== src/rcf_defs.vh
// Register map, field positions and reset values of the reset cause block
`ifndef RCF_DEFS_VH
`define RCF_DEFS_VH

// Register byte offsets on the APB word bus
`define RCF_OFS_CAUSE 12'h000
`define RCF_OFS_ISTAT 12'h004
`define RCF_OFS_IMASK 12'h008
`define RCF_OFS_BOOT 12'h00c

// Width of the flag field inside each register
`define RCF_NFLAG 6

// Bit positions of the reset cause flags
`define RCF_BIT_POR 0
`define RCF_BIT_BOD 1
`define RCF_BIT_EXT 2
`define RCF_BIT_WDT 3
`define RCF_BIT_SW 4
`define RCF_BIT_DBG 5

// Bit position of the boot pending flag in the boot register
`define RCF_BIT_PEND 0

// Reset values (power-on leaves only the power-on flag set)
`define RCF_RST_CAUSE 6'h01
`define RCF_RST_ISTAT 6'h01
`define RCF_RST_IMASK 6'h00
`define RCF_RST_PEND 1'b1

`endif

// ===== src/rcf_flag_cell.v
// One sticky flag bit with force, set and clear inputs
`timescale 1ns/1ps

module rcf_flag_cell
#(
   parameter [0:0] RST_VAL = 1'b0
)
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire force_in,
   input wire force_val,
   input wire set_in,
   input wire clr_in,
   // Flag state
   output reg flag_q
);

   // Next value of the flag
   reg flag_d;

   // Force beats set, set beats clear so no event is lost
   always @*
   begin
      flag_d = flag_q;
      if (force_in)
      begin
         // Power-on style forcing to a fixed value
         flag_d = force_val;
      end
      else if (set_in)
      begin
         // Event arriving in the clearing cycle still wins
         flag_d = 1'b1;
      end
      else if (clr_in)
      begin
         // Software clear
         flag_d = 1'b0;
      end
   end

   // Flag storage
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= RST_VAL;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

endmodule // rcf_flag_cell

// ===== src/rcf_top.v
// Reset cause flag register with APB access and event interrupt
`timescale 1ns/1ps
`include "rcf_defs.vh"

module rcf_top
(
   // APB clock and reset (presetn acts as the power-on reset)
   input wire pclk,
   input wire presetn,
   // APB slave request
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // APB slave answer
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Reset request pulses from the reset controller
   // (each high cycle counts as one request)
   input wire por_evt,
   input wire bod_evt,
   input wire ext_evt,
   input wire wdt_evt,
   input wire sw_evt,
   input wire dbg_evt,
   // Boot sequence finished
   input wire boot_done,
   // Block state
   output reg [5:0] reset_cause_q,
   output reg boot_pending_q,
   output reg irq_q
);

   // Reset values as vectors, so each flag cell takes its own bit
   localparam [`RCF_NFLAG-1:0] CAUSE_RST = `RCF_RST_CAUSE;
   localparam [`RCF_NFLAG-1:0] ISTAT_RST = `RCF_RST_ISTAT;

   // Flag storage of the cause register
   wire [`RCF_NFLAG-1:0] cause_flag;
   // Flag storage of the interrupt status register
   wire [`RCF_NFLAG-1:0] istat_flag;
   // Interrupt mask register
   reg [`RCF_NFLAG-1:0] imask_q;
   // Boot pending flag that blocks cause setting
   reg pend_q;
   // Reset request pulses as one vector
   wire [`RCF_NFLAG-1:0] evt;
   // Cause sets after gating by the boot pending flag
   wire [`RCF_NFLAG-1:0] cause_set;
   // Read data selected by address
   reg [31:0] rd_data;
   // Write-one clear strobes of the cause flags
   wire [`RCF_NFLAG-1:0] cause_clr;
   // Read clear strobes, only for bits the answer carried
   wire [`RCF_NFLAG-1:0] istat_clr;
   // Interrupt request before its output flop
   wire irq_d;

   // Access phase of an APB transfer
   wire acc;
   // Transfer completes at this edge
   wire xfer_done;
   // Completing write
   wire wr_done;
   // Completing read
   wire rd_done;
   // Address decode, one strobe per register word
   // Cause register at the base of the block
   wire hit_cause;
   // Interrupt status, cleared by reading it
   wire hit_istat;
   // Interrupt mask
   wire hit_imask;
   // Boot status, read only
   wire hit_boot;
   // Any mapped word; other words answer with an error
   wire hit_any;
   // Other cause flags may be set
   wire allow_set;

   // Gather the request pulses at their flag positions
   // The same position is the flag's bit in every register
   assign evt[`RCF_BIT_POR] = por_evt;
   assign evt[`RCF_BIT_BOD] = bod_evt;
   assign evt[`RCF_BIT_EXT] = ext_evt;
   assign evt[`RCF_BIT_WDT] = wdt_evt;
   assign evt[`RCF_BIT_SW] = sw_evt;
   assign evt[`RCF_BIT_DBG] = dbg_evt;

   // APB phase tracking; pready is a flop so every access waits once
   // Writes and read clears act only at the edge that ends the access
   assign acc = psel & penable;
   assign xfer_done = acc & pready;
   assign wr_done = xfer_done & pwrite;
   assign rd_done = xfer_done & ~pwrite;

   // Register decode on word addresses
   // Exact match, so aliases of a word answer with an error
   assign hit_cause = (paddr == `RCF_OFS_CAUSE);
   assign hit_istat = (paddr == `RCF_OFS_ISTAT);
   assign hit_imask = (paddr == `RCF_OFS_IMASK);
   assign hit_boot = (paddr == `RCF_OFS_BOOT);
   assign hit_any = hit_cause | hit_istat | hit_imask | hit_boot;

   // Sets of other flags are held off while boot is pending; a power-on
   // in the same cycle blocks them too, so the forced value stays clean
   assign allow_set = ~pend_q & ~por_evt;

   // Power-on flag is set by its own event, never gated
   assign cause_set[`RCF_BIT_POR] = evt[`RCF_BIT_POR];

   // Remaining flags only set once boot has finished
   // A held-off event is dropped, not kept until boot ends
   assign cause_set[`RCF_NFLAG-1:1] =
      evt[`RCF_NFLAG-1:1] & {(`RCF_NFLAG-1){allow_set}};

   // Write-one clear; bits written as zero keep their flag
   assign cause_clr = {`RCF_NFLAG{wr_done & hit_cause}} &
      pwdata[`RCF_NFLAG-1:0];

   // Read clear drops only the bits that the answer carried; a flag
   // raised after the answer was prepared waits for the next read
   assign istat_clr = {`RCF_NFLAG{rd_done & hit_istat}} &
      prdata[`RCF_NFLAG-1:0];

   // Level request while any unmasked status bit is set
   assign irq_d = |(istat_flag & imask_q);

   // One cause flag and one interrupt status flag per reset source
   // Flag index, also the bit position in each register
   genvar gi;
   generate
      for (gi = 0; gi < `RCF_NFLAG; gi = gi + 1)
      begin : g_flag
         // Cause flag: power-on forces, event sets, write-one clears
         rcf_flag_cell
         #(
            .RST_VAL(CAUSE_RST[gi])
         )
         u_cause
         (
            .pclk(pclk),
            .presetn(presetn),
            .force_in(por_evt),
            .force_val(gi == `RCF_BIT_POR),
            .set_in(cause_set[gi]),
            .clr_in(cause_clr[gi]),
            .flag_q(cause_flag[gi])
         );

         // Interrupt status: any source event sets, a read clears;
         // events held off from the cause flags still show here
         rcf_flag_cell
         #(
            .RST_VAL(ISTAT_RST[gi])
         )
         u_istat
         (
            .pclk(pclk),
            .presetn(presetn),
            .force_in(1'b0),
            .force_val(1'b0),
            .set_in(evt[gi]),
            .clr_in(istat_clr[gi]),
            .flag_q(istat_flag[gi])
         );
      end
   endgenerate

   // Boot pending: armed by power-on, released by boot completion
   // boot_done during a power-on leaves it armed
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Power-on reset starts a boot
         // and holds off the other cause flags
         pend_q <= `RCF_RST_PEND;
      end
      else if (por_evt)
      begin
         // A new power-on restarts the boot window
         pend_q <= 1'b1;
      end
      else if (boot_done)
      begin
         // Boot finished, other flags may now be set
         pend_q <= 1'b0;
      end
   end

   // Interrupt mask register, plain read/write
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Every interrupt masked after reset
         imask_q <= `RCF_RST_IMASK;
      end
      else if (wr_done & hit_imask)
      begin
         // Only the flag field is stored
         imask_q <= pwdata[`RCF_NFLAG-1:0];
      end
   end

   // Read data selection; unused upper bits read zero
   always @*
   begin
      rd_data = 32'h0000_0000;
      case (1'b1)
         hit_cause:
         begin
            // Bits 7:6 and above stay zero
            rd_data[`RCF_NFLAG-1:0] = cause_flag;
         end
         hit_istat:
         begin
            // Status flags as they stand now
            rd_data[`RCF_NFLAG-1:0] = istat_flag;
         end
         hit_imask:
         begin
            // Mask as last written
            rd_data[`RCF_NFLAG-1:0] = imask_q;
         end
         hit_boot:
         begin
            // Only the pending bit is defined
            rd_data[`RCF_BIT_PEND] = pend_q;
         end
         default:
         begin
            // Unmapped address reads zero
            // and the answer carries an error
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // APB answer: one wait cycle, then pready with data and error
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (acc & ~pready)
      begin
         // Answer on the edge after the first access cycle
         // A write answers with zero data
         pready <= 1'b1;
         pslverr <= ~hit_any;
         prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
      else
      begin
         // Drop the answer after its completing edge
         // Outputs idle at zero between transfers
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   // Mirror of block state onto flopped outputs
   // These lag the flags by one cycle; the bus reads the flags
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Same values as the internal reset state
         reset_cause_q <= `RCF_RST_CAUSE;
         boot_pending_q <= `RCF_RST_PEND;
         irq_q <= 1'b0;
      end
      else
      begin
         // One cycle copy of the internal state
         reset_cause_q <= cause_flag;
         boot_pending_q <= pend_q;
         // Level interrupt from its next value
         irq_q <= irq_d;
      end
   end

endmodule // rcf_top
